// ---- verilog/ledrp_pkg.sv ----
// constants for the led driver register pointer block
`default_nettype none
package ledrp_pkg;
  localparam int unsigned IDX_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned NUM_REGS = 18;
  localparam logic [4:0] IDX_MODE_CONTROL_FIRST = 5'h00;
  localparam logic [4:0] IDX_MODE_CONTROL_SECOND = 5'h01;
  localparam logic [4:0] IDX_CH0 = 5'h02;
  localparam logic [4:0] IDX_CH7 = 5'h09;
  localparam logic [4:0] IDX_GRP_DUTY = 5'h0A;
  localparam logic [4:0] IDX_GRP_PERIOD = 5'h0B;
  localparam logic [4:0] IDX_OUT_LOW = 5'h0C;
  localparam logic [4:0] IDX_OUT_HIGH = 5'h0D;
  localparam logic [4:0] IDX_SUB_A = 5'h0E;
  localparam logic [4:0] IDX_SUB_B = 5'h0F;
  localparam logic [4:0] IDX_SUB_C = 5'h10;
  localparam logic [4:0] IDX_BCAST = 5'h11;
  localparam logic [4:0] IDX_LAST = 5'h11;
  localparam int unsigned OPT_LSB = 5;
  localparam logic [2:0] OPT_NONE = 3'h0;
  localparam logic [2:0] OPT_ALL = 3'h4;
  localparam logic [2:0] OPT_DUTY = 3'h5;
  localparam logic [2:0] OPT_GROUP = 3'h6;
  localparam logic [2:0] OPT_DUTY_GROUP = 3'h7;
  localparam logic [7:0] RST_MODE_CONTROL_FIRST = 8'h11;
  localparam logic [7:0] RST_MODE_CONTROL_SECOND = 8'h00;
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_GRP_DUTY = 8'hFF;
  localparam logic [7:0] RST_GRP_PERIOD = 8'h00;
  localparam logic [7:0] RST_OUT = 8'h00;
  localparam logic [7:0] RST_SUB_A = 8'h92;
  localparam logic [7:0] RST_SUB_B = 8'h94;
  localparam logic [7:0] RST_SUB_C = 8'h98;
  localparam logic [7:0] RST_BCAST = 8'h90;
  localparam logic [7:0] MODE_CONTROL_FIRST_WMASK = 8'h1F;
  localparam logic [7:0] MODE_CONTROL_SECOND_WMASK = 8'h28;
  localparam logic [7:0] PTR_RST = 8'h00;
endpackage : ledrp_pkg
`default_nettype wire

// ---- verilog/ledrp_advance.sv ----
// next register index from the current index and the increment option
`timescale 1ns/1ps
`default_nettype none
module ledrp_advance (
  input wire logic [4:0] idx, // current index
  input wire logic [2:0] opt, // increment option
  output logic [4:0] idx_next // index after one access
);
  wire logic [4:0] inc = idx + 5'h01;

  always_comb begin
    idx_next = idx;
    unique case (opt)
      ledrp_pkg::OPT_ALL: idx_next = (idx >= ledrp_pkg::IDX_LAST) ? ledrp_pkg::IDX_MODE_CONTROL_FIRST : inc;
      ledrp_pkg::OPT_DUTY: idx_next = (idx >= ledrp_pkg::IDX_CH7) ? ledrp_pkg::IDX_CH0 : inc;
      ledrp_pkg::OPT_GROUP: idx_next = (idx >= ledrp_pkg::IDX_GRP_PERIOD) ? ledrp_pkg::IDX_GRP_DUTY : inc;
      ledrp_pkg::OPT_DUTY_GROUP: idx_next = (idx >= ledrp_pkg::IDX_GRP_PERIOD) ? ledrp_pkg::IDX_CH0 : inc;
      // reserved options 001..011 are not to be written; hold the index, the safest reading
      default: idx_next = idx;
    endcase
  end
endmodule : ledrp_advance
`default_nettype wire

// ---- verilog/ledrp_top.sv ----
// register bank and pointer byte behind the two-wire slave byte interface
//
// Operation
// - after an address match the first written byte of the transaction loads the pointer byte.
// - pointer bits 4..0 are the index of the register the next access reaches.
// - pointer bits 7..5 are the increment option, bit 7 enabling and bits 6..5 choosing the range.
// - with increment enabled the index advances by one after every data byte read or written.
// - with option 000 the index stays fixed and repeated writes overwrite the same register.
// - option 100 covers all registers and wraps from 11h to 00h.
// - option 101 covers the channel duty registers and wraps from 09h to 02h.
// - option 110 covers the two group registers and wraps from 0Bh to 0Ah.
// - option 111 covers the duty and group registers and wraps from 0Bh to 02h.
// - advancing changes only the index bits, the option bits keep their written value.
// - the written index, anywhere from 00h to 11h, is the first register accessed.
// - advancing and wrapping go on for as long as data bytes continue.
// - the map holds mode 00/01, duty 02-09, group duty 0A, period 0B, outputs 0C/0D, calls 0E-10, broadcast 11.
// - the top three bits of the first mode register read back the increment option.
`timescale 1ns/1ps
`default_nettype none
module ledrp_top #(
  parameter int unsigned NUM_CH = 8 // number of duty registers
) (
  input wire logic clk, // 200 MHz clock
  input wire logic arst_n, // async reset, active low
  input wire logic xfer_start, // pulse: address matched, transaction begins
  input wire logic xfer_stop, // pulse: transaction ended
  input wire logic wr_valid, // pulse: a received data byte
  input wire logic [7:0] wr_data, // received byte
  input wire logic rd_take, // pulse: byte on rd_data was shifted out
  output logic [7:0] rd_data, // byte to send on next read
  output logic [7:0] pointer, // pointer byte
  output logic [7:0] mode_first, // first mode register
  output logic [7:0] mode_second, // second mode register
  output logic [8*NUM_CH-1:0] duty_flat, // channel duties, channel 0 lowest
  output logic [7:0] grp_duty, // group duty
  output logic [7:0] grp_period, // group period
  output logic [15:0] out_state, // output states, low register lowest
  output logic [7:0] sub_a, // secondary call address a
  output logic [7:0] sub_b, // secondary call address b
  output logic [7:0] sub_c, // secondary call address c
  output logic [7:0] bcast // broadcast call address
);
  // the map has room for exactly eight duty registers
  if (NUM_CH != 8) begin : g_bad_num_ch
    $error("ledrp_top serves exactly eight channels");
  end

  logic [7:0] regs_reg [0:17];
  logic [7:0] ptr_reg;
  logic ptr_due_reg;
  logic [7:0] rd_data_reg;

  wire logic [4:0] idx = ptr_reg[4:0];
  wire logic [2:0] opt = ptr_reg[7:5];
  wire logic [4:0] idx_adv;
  wire logic load_ptr = wr_valid && ptr_due_reg;
  wire logic data_wr = wr_valid && !ptr_due_reg;
  wire logic access = data_wr || rd_take;
  wire logic in_map = idx <= ledrp_pkg::IDX_LAST;
  wire logic [4:0] rd_idx = load_ptr ? wr_data[4:0] : (access ? idx_adv : idx);

  ledrp_advance u_adv (
    .idx(idx),
    .opt(opt),
    .idx_next(idx_adv)
  );

  function automatic logic [7:0] reset_value(input int unsigned i);
    if (i == 0) return ledrp_pkg::RST_MODE_CONTROL_FIRST;
    if (i == 1) return ledrp_pkg::RST_MODE_CONTROL_SECOND;
    if (i <= 9) return ledrp_pkg::RST_DUTY;
    if (i == 10) return ledrp_pkg::RST_GRP_DUTY;
    if (i == 11) return ledrp_pkg::RST_GRP_PERIOD;
    if (i <= 13) return ledrp_pkg::RST_OUT;
    if (i == 14) return ledrp_pkg::RST_SUB_A;
    if (i == 15) return ledrp_pkg::RST_SUB_B;
    if (i == 16) return ledrp_pkg::RST_SUB_C;
    return ledrp_pkg::RST_BCAST;
  endfunction : reset_value

  // read view: mode 1 top bits mirror the live option, mode 2 reserved bits stay zero
  function automatic logic [7:0] view(input logic [4:0] i, input logic [2:0] o, input logic [7:0] raw);
    if (i == ledrp_pkg::IDX_MODE_CONTROL_FIRST) return {o, raw[4:0]};
    if (i == ledrp_pkg::IDX_MODE_CONTROL_SECOND) return raw & ledrp_pkg::MODE_CONTROL_SECOND_WMASK;
    return raw;
  endfunction : view

  wire logic [2:0] rd_opt = load_ptr ? wr_data[7:5] : opt;
  wire logic [7:0] rd_raw = (rd_idx <= ledrp_pkg::IDX_LAST) ? regs_reg[rd_idx] : 8'h00;
  wire logic [7:0] rd_next = view(rd_idx, rd_opt, rd_raw);

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_due_reg <= 1'b0;
    end else if (xfer_start) begin
      ptr_due_reg <= 1'b1;
    end else if (wr_valid || xfer_stop || rd_take) begin
      ptr_due_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ptr_reg <= ledrp_pkg::PTR_RST;
    end else if (load_ptr) begin
      ptr_reg <= wr_data;
    end else if (access) begin
      ptr_reg <= {opt, idx_adv};
    end
  end

  genvar g;
  generate
    for (g = 0; g < 18; g++) begin : g_reg
      always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
          regs_reg[g] <= reset_value(g);
        end else if (data_wr && in_map && idx == 5'(g)) begin
          if (g == 0) regs_reg[g] <= (wr_data & ledrp_pkg::MODE_CONTROL_FIRST_WMASK) | (regs_reg[g] & ~ledrp_pkg::MODE_CONTROL_FIRST_WMASK);
          else if (g == 1) regs_reg[g] <= wr_data & ledrp_pkg::MODE_CONTROL_SECOND_WMASK;
          else regs_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_reg <= ledrp_pkg::RST_MODE_CONTROL_FIRST & ledrp_pkg::MODE_CONTROL_FIRST_WMASK;
    end else begin
      rd_data_reg <= rd_next;
    end
  end

  // outputs are the storage flops themselves
  always_comb begin
    rd_data = rd_data_reg;
    pointer = ptr_reg;
    mode_first = regs_reg[0];
    mode_second = regs_reg[1];
    for (int i = 0; i < 8; i++) begin
      duty_flat[8*i +: 8] = regs_reg[2+i];
    end
    grp_duty = regs_reg[10];
    grp_period = regs_reg[11];
    out_state = {regs_reg[13], regs_reg[12]};
    sub_a = regs_reg[14];
    sub_b = regs_reg[15];
    sub_c = regs_reg[16];
    bcast = regs_reg[17];
  end
endmodule : ledrp_top
`default_nettype wire

// ---- bench/ledrp_chk.sv ----
// port checks for the register pointer block
`timescale 1ns/1ps
`default_nettype none
module ledrp_chk (
  input wire logic clk, // clock
  input wire logic arst_n, // async reset, active low
  input wire logic xfer_start, // address matched
  input wire logic wr_valid, // byte written
  input wire logic [7:0] wr_data, // written byte
  input wire logic rd_take, // byte read
  input wire logic [7:0] rd_data, // byte to send
  input wire logic [7:0] pointer // pointer byte
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  // read advance alone, so a write or pointer load cannot mask it
  wire logic adv = rd_take && !wr_valid && !xfer_start;
  property p_load; xfer_start ##1 !wr_valid ##1 wr_valid |=> pointer == $past(wr_data); endproperty
  a_load: assert property (p_load) else $error("pointer byte not loaded");
  property p_opt; adv |=> pointer[7:5] == $past(pointer[7:5]); endproperty
  a_opt: assert property (p_opt) else $error("option bits changed");
  property p_fix; adv && pointer[7:5] == 3'h0 |=> $stable(pointer); endproperty
  a_fix: assert property (p_fix) else $error("fixed index moved");
  property p_all_wrap; adv && pointer == 8'h91 |=> pointer == 8'h80; endproperty
  a_all_wrap: assert property (p_all_wrap) else $error("full range wrap wrong");
  property p_duty_wrap; adv && pointer == 8'hA9 |=> pointer == 8'hA2; endproperty
  a_duty_wrap: assert property (p_duty_wrap) else $error("duty range wrap wrong");
  property p_grp_wrap; adv && pointer == 8'hCB |=> pointer == 8'hCA; endproperty
  a_grp_wrap: assert property (p_grp_wrap) else $error("group range wrap wrong");
  property p_both_wrap; adv && pointer == 8'hEB |=> pointer == 8'hE2; endproperty
  a_both_wrap: assert property (p_both_wrap) else $error("duty and group wrap wrong");
  property p_view; pointer[4:0] == 5'h00 ##1 $stable(pointer) |-> rd_data[7:5] == pointer[7:5]; endproperty
  a_view: assert property (p_view) else $error("mode view of option wrong");
  c_all_wrap: cover property (adv && pointer == 8'h91);
  c_grp_wrap: cover property (adv && pointer == 8'hCB);
  c_fixed: cover property (wr_valid && pointer[7:5] == 3'h0);
endmodule : ledrp_chk
bind ledrp_top ledrp_chk i_ledrp_chk (.clk, .arst_n, .xfer_start, .wr_valid, .wr_data, .rd_take, .rd_data, .pointer);
`default_nettype wire

// ---- bench/ledrp_master.sv ----
// byte-level two-wire master model
`timescale 1ns/1ps
`default_nettype none
module ledrp_master (
  input wire logic clk, // block clock
  output logic xfer_start, // address matched
  output logic xfer_stop, // transaction over
  output logic wr_valid, // byte written
  output logic [7:0] wr_data, // written byte
  output logic rd_take // byte read
);
  initial begin
    {xfer_start, xfer_stop, wr_valid, rd_take} = 4'h0;
    wr_data = 8'h5A;
  end
  // kind is {start, stop, write, read}; the data line toggles when it carries no byte
  task automatic strobe(input logic [3:0] kind, input logic [7:0] b);
    @(negedge clk);
    wr_data = kind[1] ? b : ~wr_data;
    {xfer_start, xfer_stop, wr_valid, rd_take} = kind;
    @(negedge clk);
    {xfer_start, xfer_stop, wr_valid, rd_take} = 4'h0;
    wr_data = ~wr_data;
  endtask : strobe
endmodule : ledrp_master
`default_nettype wire

// ---- bench/ledrp_top_tb.sv ----
// self-checking bench for the register pointer block
`timescale 1ns/1ps
`default_nettype none
module ledrp_top_tb;
  logic clk, arst_n, xfer_start, xfer_stop, wr_valid, rd_take;
  logic [7:0] wr_data, rd_data, pointer, ptr, got, mode_control_second_q, bcast_q;
  logic [7:0] model [0:17];
  logic [7:0] notes [$];
  logic [7:0] ptrs [5] = '{8'h91, 8'hA3, 8'hC5, 8'hE9, 8'h07};
  int miscompares = 0;
  int checks_done = 0;
  int seed = 32'h7de81d4b;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  ledrp_master i_ledrp_master (.clk(clk), .xfer_start(xfer_start), .xfer_stop(xfer_stop), .wr_valid(wr_valid),
    .wr_data(wr_data), .rd_take(rd_take));
  ledrp_top i_ledrp_top (.clk(clk), .arst_n(arst_n), .xfer_start(xfer_start), .xfer_stop(xfer_stop),
    .wr_valid(wr_valid), .wr_data(wr_data), .rd_take(rd_take), .rd_data(rd_data), .pointer(pointer),
    .mode_first(), .mode_second(mode_control_second_q), .duty_flat(), .grp_duty(), .grp_period(), .out_state(), .sub_a(),
    .sub_b(), .sub_c(), .bcast(bcast_q));
  function automatic logic [4:0] step(input logic [7:0] p);
    case (p[7:5])
      3'h4: step = (p[4:0] == 5'h11) ? 5'h00 : p[4:0] + 5'h01;
      3'h5: step = (p[4:0] == 5'h09) ? 5'h02 : p[4:0] + 5'h01;
      3'h6: step = (p[4:0] == 5'h0B) ? 5'h0A : p[4:0] + 5'h01;
      3'h7: step = (p[4:0] == 5'h0B) ? 5'h02 : p[4:0] + 5'h01;
      default: step = p[4:0];
    endcase
  endfunction : step
  task automatic put_ptr(input logic [7:0] p);
    i_ledrp_master.strobe(4'h4, 8'h00);
    i_ledrp_master.strobe(4'h8, 8'h00);
    i_ledrp_master.strobe(4'h2, p);
    ptr = p;
  endtask : put_ptr
  task automatic put(input logic [7:0] d);
    i_ledrp_master.strobe(4'h2, d);
    if (ptr[4:0] == 5'h00) model[0][4:0] = d[4:0];
    else if (ptr[4:0] == 5'h01) model[1] = d & 8'h28;
    else model[ptr[4:0]] = d;
    ptr[4:0] = step(ptr);
  endtask : put
  task automatic get();
    notes.push_back(ptr[4:0] == 5'h00 ? {ptr[7:5], model[0][4:0]} : model[ptr[4:0]]);
    i_ledrp_master.strobe(4'h1, 8'h00);
    ptr[4:0] = step(ptr);
  endtask : get
  always @(posedge clk) begin
    if (rd_take === 1'b1) begin
      got = (notes.size() > 0) ? notes.pop_front() : 8'hXX;
      checks_done++;
      if (rd_data !== got) begin
        miscompares++;
        $display("ERROR at %0t: got %h expected %h", $time, rd_data, got);
      end
    end
  end
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  initial begin
    arst_n = 1'b0;
    model = '{8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
      8'h00, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h92, 8'h94, 8'h98, 8'h90};
    repeat (2) @(posedge clk);
    @(negedge clk) arst_n <= 1'b1;
    put_ptr(8'h80);
    repeat (19) get();
    $display("test reset values done");
    put_ptr(8'h80);
    repeat (18) put(8'($random(seed)));
    put_ptr(8'h80);
    repeat (18) get();
    $display("test full write and read done");
    foreach (ptrs[i]) begin
      put_ptr(ptrs[i]);
      repeat (12) put(8'($random(seed)));
      put_ptr(ptrs[i]);
      repeat (12) get();
      $display("test option %h done", ptrs[i]);
    end
    repeat (2) @(negedge clk);
    checks_done++;
    if ({mode_control_second_q, bcast_q} !== {model[1], model[17]}) begin
      miscompares++;
      $display("ERROR at %0t: got %h expected %h", $time, {mode_control_second_q, bcast_q}, {model[1], model[17]});
    end
    $display("test register outputs done");
    wrap_up();
  end
  initial begin
    #100000;
    miscompares++;
    wrap_up();
  end
endmodule : ledrp_top_tb
`default_nettype wire
